// *** remote_node.sv ***
//
// Purpose: Remote serial node and transmit shifter stand-in
// Assumes: Each received bit gives one strobe with one tick
// Notes:   Sample lines toggle while no bit is offered
//
`timescale 1ns/100ps
`default_nettype none
module remote_node
(
  input  wire logic  clock_in,
  output logic       tx_load_out,
  output logic       tx_busy_out,
  output logic       line_out,
  output logic       tick_out,
  output logic       strobe_out,
  output logic       start_out,
  output logic [6:0] samples_out
);
  initial
    {tx_load_out, tx_busy_out, tick_out, strobe_out, start_out, samples_out, line_out} = 13'h1;
  task automatic put_bit(input logic b, input logic s, input logic [6:0] smp);
    @(posedge clock_in) {line_out, tick_out, strobe_out, start_out, samples_out} <= {b, 2'b11, s, smp};
    @(posedge clock_in) {tick_out, strobe_out, start_out, samples_out} <= {3'b000, ~smp};
  endtask : put_bit
  task automatic frame_n(input logic [8:0] d, input int n, input logic stop, input logic noisy);
    put_bit(1'b0, 1'b1, {4'h0, noisy, 2'b00});
    for (int i = 0; i < n; i++)
      put_bit(d[i], 1'b0, {4'h0, {3{d[i]}}});
    put_bit(stop, 1'b0, {4'h0, {3{stop}}});
    line_out <= 1'b1;
  endtask : frame_n
  task automatic frame(input logic [7:0] d, input logic stop, input logic noisy);
    frame_n({1'b0, d}, 8, stop, noisy);
  endtask : frame
  task automatic idle(input int n);
    repeat (2 * n) @(posedge clock_in) tick_out <= ~tick_out;
  endtask : idle
  task automatic shift;
    @(posedge clock_in) {tx_load_out, tx_busy_out} <= 2'b11;
    @(posedge clock_in) tx_load_out <= 1'b0;
    @(posedge clock_in) tx_busy_out <= 1'b0;
  endtask : shift
endmodule : remote_node
`default_nettype wire

// *** status_flags_chk.sv ***
//
// Purpose: Port assertions for the serial status flags
// Assumes: One clock, reset active low
// Notes:   Clear arming is rebuilt from bus traffic
//
`timescale 1ns/100ps
`default_nettype none
module status_flags_chk
(
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic [3:0]  address_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  input wire logic        tx_load_in,
  input wire logic        bit_tick_in,
  input wire logic        rx_bit_strobe_in,
  input wire logic [8:0]  rx_data_out,
  input wire logic [7:0]  status_out
);
  import uart_status_pkg::*;
  logic [7:0] arm;
  logic       blocked;
  logic       acc;
  assign acc = !waitrequest_out && (read_in || write_in);
  // Flags seen by the last status read
  always_ff @(posedge clock_in or negedge rstn_in)
    if (!rstn_in)
      {arm, blocked} <= 9'h000;
    else
    begin
      if (acc && read_in && address_in == addr_status)
        arm <= readdata_out[7:0];
      else if (acc && address_in == addr_data)
        arm <= 8'h00;
      blocked <= $fell(status_out[bit_idle]) || (blocked && !status_out[bit_rx_buffer_full]);
    end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  reset_flags_a: assert property ($rose(rstn_in) |-> status_out == status_reset)
    else $error("flags wrong after reset");
  tx_buffer_empty_set_a: assert property (tx_load_in |=> status_out[bit_tx_buffer_empty])
    else $error("buffer empty not set");
  status_ro_a: assert property (acc && write_in && address_in == addr_status
    && !rx_bit_strobe_in && !bit_tick_in |=> status_out[5:0] == $past(status_out[5:0]))
    else $error("status changed by write");
  rx_clear_a: assert property (acc && read_in && address_in == addr_data
    && !rx_bit_strobe_in && !bit_tick_in |=> (status_out[5:0] & $past(arm[5:0])) == 6'h00)
    else $error("armed receive flags kept");
  tx_buffer_empty_clear_a: assert property (acc && write_in && address_in == addr_data
    && arm[bit_tx_buffer_empty] && !tx_load_in |=> !status_out[bit_tx_buffer_empty])
    else $error("buffer empty kept");
  rx_hold_a: assert property (status_out[bit_rx_buffer_full] && !(acc && read_in)
    |=> $stable(rx_data_out))
    else $error("unread data replaced");
  idle_once_a: assert property (blocked && !status_out[bit_rx_buffer_full] |=> !status_out[bit_idle])
    else $error("idle set again");
  err_full_a: assert property ($rose(status_out[bit_nf]) || $rose(status_out[bit_fe])
    || $rose(status_out[bit_pf]) |-> $rose(status_out[bit_rx_buffer_full]))
    else $error("error flag without full");
endmodule : status_flags_chk
`default_nettype wire

// *** testbench.sv ***
//
// Purpose: Self-checking bench for the serial status flags
// Assumes: Waitrequest answers within a few cycles
// Notes:   Remote node drives the shifter and sampler inputs
//
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import uart_status_pkg::*;
  localparam logic [3:0]  tc_adr[3] = '{addr_data, addr_control, addr_control};
  localparam logic [31:0] tc_dat[3] = '{32'h155, 32'h1, 32'h2};
  localparam logic [7:0]  tc_flg[3] = '{8'h00, 8'h80, 8'h80};
  localparam logic [31:0] pa_ctl[4] = '{32'h4, 32'h4, 32'hc, 32'hc};
  localparam logic [7:0]  pa_chr[4] = '{8'ha5, 8'h25, 8'ha5, 8'h25};
  localparam logic [7:0]  pa_flg[4] = '{8'he0, 8'he1, 8'he1, 8'he0};
  logic        clock_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [3:0]  address_in = 4'h0;
  logic        read_in = 1'b0;
  logic        write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic [31:0] readdata_out, q;
  logic        waitrequest_out, tx_load_in, tx_busy_in, rx_line_in, bit_tick_in;
  logic        rx_bit_strobe_in, rx_bit_is_start_in, tx_buffer_full_out, tx_enable_out;
  logic        tx_preamble_req_out, break_queue_out;
  logic [6:0]  rx_samples_in;
  logic [8:0]  tx_data_out, rx_data_out;
  logic [7:0]  status_out;
  int          num_errors = 0;
  int          checked = 0;
  always #10 clock_in = ~clock_in;
  remote_node node (.clock_in, .tx_load_out(tx_load_in), .tx_busy_out(tx_busy_in),
    .line_out(rx_line_in), .tick_out(bit_tick_in), .strobe_out(rx_bit_strobe_in),
    .start_out(rx_bit_is_start_in), .samples_out(rx_samples_in));
  uart_status_flags i_dut (.clock_in, .rstn_in, .address_in, .read_in, .write_in,
    .writedata_in, .readdata_out, .waitrequest_out, .tx_load_in, .tx_busy_in, .tx_data_out,
    .tx_buffer_full_out, .tx_enable_out, .tx_preamble_req_out, .break_queue_out, .rx_line_in,
    .bit_tick_in, .rx_bit_strobe_in, .rx_bit_is_start_in, .rx_samples_in, .rx_data_out,
    .status_out);
  task automatic complete_run;
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Avalon access, held until waitrequest is seen low
  task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in) {read_in, write_in, address_in, writedata_in} <= {r, !r, a, d};
    @(posedge clock_in);
    while (waitrequest_out !== 1'b0 && n < 40)
    begin
      @(posedge clock_in);
      n++;
    end
    q = readdata_out;
    {read_in, write_in} <= 2'b00;
    if (n == 40)
    begin
      num_errors++;
      complete_run;
    end
  endtask : bus
  task automatic st(input logic [7:0] e);
    bus(1'b1, addr_status, 32'h0);
    chk("status", {24'h0, e}, q);
  endtask : st
  task automatic clr;
    bus(1'b1, addr_status, 32'h0);
    bus(1'b1, addr_data, 32'h0);
  endtask : clr
  initial
  begin
    repeat (20) @(posedge clock_in);
    rstn_in <= 1'b1;
    st(status_reset);
    bus(1'b0, addr_status, 32'hff);
    st(status_reset);
    bus(1'b1, 4'hc, 32'h0);
    chk("unmapped read", 32'h0, q);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, addr_control, 32'h0);
      node.shift;
      st(status_reset);
      bus(1'b0, tc_adr[i], tc_dat[i]);
      st(tc_flg[i]);
      chk("tx enable", {31'h0, i == 1}, {31'h0, tx_enable_out});
      chk("preamble", {31'h0, i == 1}, {31'h0, tx_preamble_req_out});
    end
    chk("tx data", 32'h155, {23'h0, tx_data_out});
    chk("break queued", 32'h1, {31'h0, break_queue_out});
    bus(1'b0, addr_control, 32'h0);
    node.shift;
    chk("tx buffer full", 32'h0, {31'h0, tx_buffer_full_out});
    node.frame(8'ha5, 1'b1, 1'b0);
    st(8'he0);
    node.frame(8'h5a, 1'b0, 1'b1);
    st(8'he8);
    clr;
    chk("rx data", 32'ha5, q);
    chk("rx data port", 32'ha5, {23'h0, rx_data_out});
    st(status_reset);
    node.frame(8'ha5, 1'b0, 1'b1);
    st(8'he6);
    clr;
    st(status_reset);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, addr_control, pa_ctl[i]);
      node.frame(pa_chr[i], 1'b1, 1'b0);
      st(pa_flg[i]);
      clr;
      st(status_reset);
    end
    bus(1'b0, addr_control, 32'h20);
    node.frame(8'h00, 1'b0, 1'b0);
    st(status_reset);
    bus(1'b0, addr_control, 32'h0);
    node.frame(8'hff, 1'b1, 1'b0);
    node.idle(1);
    st(8'hf0);
    clr;
    node.idle(12);
    st(status_reset);
    bus(1'b0, addr_control, 32'h10);
    node.frame(8'hff, 1'b1, 1'b0);
    node.idle(9);
    st(8'he0);
    node.idle(1);
    st(8'hf0);
    clr;
    bus(1'b0, addr_control, 32'h40);
    node.frame_n(9'h1ff, 9, 1'b1, 1'b0);
    st(8'he0);
    node.idle(1);
    st(8'hf0);
    clr;
    chk("nine bit data", 32'h1ff, q);
    complete_run;
  end
endmodule : testbench
bind uart_status_flags status_flags_chk u_chk (.clock_in, .rstn_in, .address_in, .read_in,
  .write_in, .readdata_out, .waitrequest_out, .tx_load_in, .bit_tick_in, .rx_bit_strobe_in,
  .rx_data_out, .status_out);
`default_nettype wire

// *** uart_status_flags.sv ***
//
// Purpose: Status flags, data register and clear sequences of a serial port
// Assumes: Shifters deliver one-cycle strobes; bit_tick_in marks bit times
// Notes:   Single cycle wait state on every bus access
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module uart_status_flags
(
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // Avalon-MM slave
  input  wire logic [3:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  // Transmit shifter
  input  wire logic        tx_load_in,
  input  wire logic        tx_busy_in,
  output logic      [8:0]  tx_data_out,
  output logic             tx_buffer_full_out,
  output logic             tx_enable_out,
  output logic             tx_preamble_req_out,
  output logic             break_queue_out,
  // Receive sampler
  input  wire logic        rx_line_in,
  input  wire logic        bit_tick_in,
  input  wire logic        rx_bit_strobe_in,
  input  wire logic        rx_bit_is_start_in,
  input  wire logic [6:0]  rx_samples_in,
  output logic      [8:0]  rx_data_out,
  output logic      [7:0]  status_out
);
  import uart_status_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]           flags;
    logic [7:0]           arm;
    logic                 resp;
    logic [31:0]          rdata;
    logic [8:0]           tx_data;
    logic [8:0]           rx_data;
    logic [ctl_width-1:0] ctrl;
    logic                 preamble;
    logic                 in_frame;
    logic [3:0]           bit_idx;
    logic [8:0]           shift;
    logic                 noise;
    logic [3:0]           idle_cnt;
    logic                 idle_armed;
  } state_t;

  state_t st;
  state_t next_st;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority3

  function automatic logic disagree(input logic [6:0] s, input int n);
    logic any_one;
    logic any_zero;
    any_one  = 1'b0;
    any_zero = 1'b0;
    for (int i = 0; i < start_samples; i++)
    begin
      if (i < n)
      begin
        any_one  = any_one | s[i];
        any_zero = any_zero | ~s[i];
      end
    end
    disagree = any_one & any_zero;
  endfunction : disagree

  // ****************************************
  // Decode
  // ****************************************
  logic       req;
  logic       accept;
  logic       rd_status;
  logic       rd_data;
  logic       wr_data;
  logic       wr_ctrl;
  logic       te_rise;
  logic       brk_write;
  logic [3:0] data_bits;
  logic [3:0] idle_need;
  logic       stop_bit;
  logic       data_bit;
  logic       bit_val;
  logic       bit_noise;
  logic       frame_err;
  logic       par_err;
  logic       rx_done;
  logic       count_ok;

  always_comb
  begin
    req       = read_in | write_in;
    accept    = req & st.resp;
    rd_status = accept & read_in & (address_in == addr_status);
    rd_data   = accept & read_in & (address_in == addr_data);
    wr_data   = accept & write_in & (address_in == addr_data);
    wr_ctrl   = accept & write_in & (address_in == addr_control);
    te_rise   = wr_ctrl & writedata_in[ctl_tx_enable] & ~st.ctrl[ctl_tx_enable];
    brk_write = wr_ctrl & writedata_in[ctl_break_queue];
    data_bits = st.ctrl[ctl_char_nine] ? data_bits_9 : data_bits_8;
    idle_need = st.ctrl[ctl_char_nine] ? idle_bits_9 : idle_bits_8;
    stop_bit  = rx_bit_strobe_in & st.in_frame & ~rx_bit_is_start_in
                & (st.bit_idx == data_bits);
    data_bit  = rx_bit_strobe_in & st.in_frame & ~rx_bit_is_start_in
                & (st.bit_idx < data_bits);
    bit_val   = majority3(rx_samples_in[2:0]);
    if (rx_bit_is_start_in)
    begin
      bit_noise = disagree(rx_samples_in, start_samples);
    end
    else
    begin
      bit_noise = disagree(rx_samples_in, bit_samples);
    end
    frame_err = stop_bit & ~bit_val;
    // Parity over all data bits including parity bit
    par_err   = st.ctrl[ctl_parity_on]
                & ((^st.shift) != st.ctrl[ctl_parity_odd]);
    rx_done   = stop_bit & ~st.ctrl[ctl_long_break];
    count_ok  = ~st.ctrl[ctl_idle_after] | ~st.in_frame;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [8:0] nshift;
    set_v   = 8'h00;
    clr_v   = 8'h00;
    nshift  = st.shift;
    next_st = st;

    // Bus: one wait state, read data latched in the wait cycle
    next_st.resp = req & ~st.resp;
    if (req & ~st.resp)
    begin
      unique case (address_in)
        addr_status:  next_st.rdata = {24'h000000, st.flags};
        addr_data:    next_st.rdata = {23'h000000, st.rx_data};
        addr_control: next_st.rdata = {25'h0000000, st.ctrl};
        default:      next_st.rdata = 32'h00000000;
      endcase
    end

    // Status read arms clears of the flags it returned
    if (rd_status)
    begin
      next_st.arm = st.rdata[7:0];
    end
    if (wr_data)
    begin
      next_st.tx_data = writedata_in[8:0];
      clr_v[bit_tx_buffer_empty] = st.arm[bit_tx_buffer_empty];
      clr_v[bit_tc]   = st.arm[bit_tc];
      next_st.arm[bit_tx_buffer_empty] = 1'b0;
    end
    if (te_rise | brk_write)
    begin
      clr_v[bit_tc] = st.arm[bit_tc];
    end
    if (wr_data | te_rise | brk_write)
    begin
      next_st.arm[bit_tc] = 1'b0;
    end
    if (rd_data)
    begin
      clr_v[bit_rx_buffer_full] = st.arm[bit_rx_buffer_full];
      clr_v[bit_idle] = st.arm[bit_idle];
      clr_v[bit_ovr]  = st.arm[bit_ovr];
      clr_v[bit_nf]   = st.arm[bit_nf];
      clr_v[bit_fe]   = st.arm[bit_fe];
      clr_v[bit_pf]   = st.arm[bit_pf];
      next_st.arm[5:0] = 6'h00;
    end
    if (wr_ctrl)
    begin
      next_st.ctrl = writedata_in[ctl_width-1:0];
    end

    // Transmit side
    if (te_rise)
    begin
      next_st.preamble = 1'b1;
    end
    else if (tx_busy_in)
    begin
      next_st.preamble = 1'b0;
    end
    set_v[bit_tx_buffer_empty] = tx_load_in;
    set_v[bit_tc]   = st.flags[bit_tx_buffer_empty] & ~tx_busy_in & ~st.preamble
                      & ~st.ctrl[ctl_break_queue] & ~te_rise
                      & ~brk_write & ~wr_data;

    // Receive framing
    if (rx_bit_strobe_in & rx_bit_is_start_in)
    begin
      next_st.in_frame = 1'b1;
      next_st.bit_idx  = 4'h0;
      next_st.noise    = bit_noise;
      nshift           = 9'h000;
    end
    else if (data_bit)
    begin
      nshift          = st.shift;
      nshift[st.bit_idx] = bit_val;
      next_st.bit_idx = st.bit_idx + 4'h1;
      next_st.noise   = st.noise | bit_noise;
    end
    else if (stop_bit)
    begin
      next_st.in_frame = 1'b0;
    end
    next_st.shift = nshift;

    if (rx_done)
    begin
      if (st.flags[bit_rx_buffer_full])
      begin
        set_v[bit_ovr] = 1'b1;
      end
      else
      begin
        next_st.rx_data = st.shift;
        set_v[bit_rx_buffer_full] = 1'b1;
        set_v[bit_nf]   = st.noise | bit_noise;
        set_v[bit_fe]   = frame_err;
        set_v[bit_pf]   = par_err;
        next_st.idle_armed = 1'b1;
        clr_v[bit_nf] = 1'b1;
        clr_v[bit_fe] = 1'b1;
        clr_v[bit_pf] = 1'b1;
      end
    end

    // Idle line detection
    if (bit_tick_in)
    begin
      if (~rx_line_in)
      begin
        next_st.idle_cnt = 4'h0;
      end
      else if (count_ok & (st.idle_cnt != idle_need))
      begin
        next_st.idle_cnt = st.idle_cnt + 4'h1;
      end
    end
    if (rx_line_in & count_ok & (st.idle_cnt == idle_need)
        & st.idle_armed)
    begin
      set_v[bit_idle]    = 1'b1;
      next_st.idle_armed = 1'b0;
    end

    // Set wins over clear; writes to the status register never touch flags
    next_st.flags = (st.flags & ~clr_v) | set_v;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st       <= '0;
      st.flags <= status_reset;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    waitrequest_out     = req & ~st.resp;
    readdata_out        = st.rdata;
    tx_data_out         = st.tx_data;
    tx_buffer_full_out  = ~st.flags[bit_tx_buffer_empty];
    tx_enable_out       = st.ctrl[ctl_tx_enable];
    tx_preamble_req_out = st.preamble;
    break_queue_out     = st.ctrl[ctl_break_queue];
    rx_data_out         = st.rx_data;
    status_out          = st.flags;
  end

endmodule : uart_status_flags

`default_nettype wire

// *** uart_status_pkg.sv ***
//
// Purpose: Constants for the serial status flag block
// Assumes: 32-bit Avalon-MM slave, one word per register
// Notes:   Flag positions follow the primary status register layout
//
// Behaviour
// - Status register is read-only; bus writes to it have no effect.
// - Transmit-buffer-empty sets at reset and on buffer-to-shifter transfer.
// - Status read with buffer-empty set, then data write, clears buffer-empty.
// - Transmission-complete sets at reset and when buffer empty and shifter idle.
// - After status read, data write, enable rise or break write clears it.
// - Receive-buffer-full sets when a character moves into receive data register.
// - Status read then data read clears receive-buffer-full.
// - Idle sets after 10 or 11 high bit times following activity.
// - Idle-count select 0 counts idle bits from just after the start bit.
// - Idle-count select 1 counts idle bits only after the stop bit.
// - Status read then data read clears the idle flag.
// - Idle sets again only after a new character sets receive-buffer-full.
// - Overrun sets when new character finds old unread; new one is dropped.
// - Status read then data read clears overrun.
// - Seven start samples, three per other bit; disagreement sets noise flag.
// - Status read then data read clears the noise flag.
// - Framing error sets with buffer-full when stop bit samples low.
// - Status read then data read clears framing error.
// - With parity on, parity mismatch sets parity error with buffer-full.
// - Status read then data read clears parity error.
// - Parity even when type bit 0, odd when 1, counting all ones.
// - Long break detection suppresses framing error and buffer-full setting.
//
package uart_status_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] addr_status  = 4'h0;
  localparam logic [3:0] addr_data    = 4'h4;
  localparam logic [3:0] addr_control = 4'h8;

  // ****************************************
  // Status flag positions
  // ****************************************
  localparam int bit_tx_buffer_empty = 7;
  localparam int bit_tc   = 6;
  localparam int bit_rx_buffer_full = 5;
  localparam int bit_idle = 4;
  localparam int bit_ovr  = 3;
  localparam int bit_nf   = 2;
  localparam int bit_fe   = 1;
  localparam int bit_pf   = 0;

  // ****************************************
  // Control register field positions
  // ****************************************
  localparam int ctl_tx_enable   = 0;
  localparam int ctl_break_queue = 1;
  localparam int ctl_parity_on   = 2;
  localparam int ctl_parity_odd  = 3;
  localparam int ctl_idle_after  = 4;
  localparam int ctl_long_break  = 5;
  localparam int ctl_char_nine   = 6;
  localparam int ctl_width       = 7;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] status_reset   = 8'hc0;
  localparam logic [3:0] idle_bits_8    = 4'ha;
  localparam logic [3:0] idle_bits_9    = 4'hb;
  localparam logic [3:0] data_bits_8    = 4'h8;
  localparam logic [3:0] data_bits_9    = 4'h9;
  localparam int         start_samples  = 7;
  localparam int         bit_samples    = 3;

endpackage : uart_status_pkg
